/* File: aam_alarm_manager.v */
`timescale 1ns/100ps
`default_nettype none
`include "aam_defines.vh"
module aam_alarm_manager #(
   parameter [31:0] SILENCE_CYC = `AAM_SILENCE_CYC
) (
   // clock and reset
   input wire CLK,
   input wire RESET,
   // detectors: per-alarm urgency, 0 means inactive
   input wire [2*`AAM_NALM-1:0] ALM_URG,
   input wire [`AAM_NALM-1:0] ALM_LIMIT_CHG,
   input wire [`AAM_NALM-1:0] ALM_SIL_BREAK,
   output reg [`AAM_NALM-1:0] ALM_REARM,
   // operator keys, one-cycle pulses; TIME_NOW is the entry time stamp
   input wire SILENCE_KEY,
   input wire RESET_KEY,
   input wire CANCEL_KEY,
   input wire NEW_PATIENT_DONE,
   input wire LOG_VIEWED,
   input wire [`AAM_TSW-1:0] TIME_NOW,
   // indicators and sound
   output reg LAMP_HIGH,
   output reg LAMP_MED,
   output reg LAMP_LOW,
   output reg LAMP_SILENCE,
   output reg TONE_ON,
   output reg [1:0] TONE_CLASS,
   // log read port, index 0 newest
   input wire [`AAM_LOG_AW-1:0] LOG_IDX,
   output reg [`AAM_TSW+3+2+`AAM_IDW-1:0] LOG_DATA,
   output reg [`AAM_LOG_AW-1:0] LOG_COUNT,
   output reg LOG_UNREAD
);
   localparam EW = `AAM_TSW + 3 + 2 + `AAM_IDW;
   localparam N = `AAM_NALM;
   localparam [31:0] FAST_CYC = `AAM_FAST_CYC;
   localparam [31:0] SLOW_CYC = `AAM_SLOW_CYC;
   localparam [31:0] TONE_CYC = `AAM_TONE_CYC;
   localparam [`AAM_LOG_AW-1:0] DEPTH = `AAM_LOG_DEPTH;
   reg [EW-1:0] log_mem [0:`AAM_LOG_DEPTH-1];
   reg [`AAM_LOG_AW-1:0] wp_r;
   reg [2*N-1:0] prev_urg_r;
   reg [N-1:0] latch_high_r;
   reg sil_r;
   reg [31:0] sil_cnt_r;
   reg [31:0] fl_cnt_r;
   reg fast_r;
   reg slow_r;
   reg [31:0] tone_cnt_r;
   reg [4:0] step_r;
   reg low_done_r;
   reg [1:0] cls_prev_r;
   reg rst_pend_r;
   integer i;
   integer j;
   // one logged event per cycle; lowest alarm index wins, others next cycle
   reg ev_valid;
   reg [2:0] ev_code;
   reg [1:0] ev_urg;
   reg [`AAM_IDW-1:0] ev_id;
   reg [N-1:0] ev_done;
   reg any_active;
   reg new_high;
   reg any_high;
   reg any_med;
   reg any_low;
   reg [1:0] u;
   reg [1:0] p;
   reg [1:0] cls;
   reg sil_end;
   reg [`AAM_LOG_AW:0] rd_w;
   reg [`AAM_LOG_AW-1:0] rd;
   function [1:0] urg_of;
      input [2*N-1:0] v;
      input integer k;
      begin
         urg_of = v[2*k +: 2];
      end
   endfunction
   always @*
   begin
      ev_valid = 1'b0;
      ev_code = `AAM_EV_DETECT;
      ev_urg = `AAM_URG_NONE;
      ev_id = {`AAM_IDW{1'b0}};
      ev_done = {N{1'b0}};
      any_active = 1'b0;
      new_high = 1'b0;
      any_high = 1'b0;
      any_med = 1'b0;
      any_low = 1'b0;
      u = 2'h0;
      p = 2'h0;
      for (i = 0; i < N; i = i + 1)
      begin
         u = urg_of(ALM_URG, i);
         p = urg_of(prev_urg_r, i);
         if (u != `AAM_URG_NONE) any_active = 1'b1;
         if (u == `AAM_URG_HIGH) any_high = 1'b1;
         if (u == `AAM_URG_MED) any_med = 1'b1;
         if (u == `AAM_URG_LOW) any_low = 1'b1;
         // only alarms allowed to break silence count here
         if (u == `AAM_URG_HIGH && p != `AAM_URG_HIGH && ALM_SIL_BREAK[i]) new_high = 1'b1;
         if (!ev_valid && u != p)
         begin
            ev_valid = 1'b1;
            ev_done[i] = 1'b1;
            ev_id = i[`AAM_IDW-1:0];
            ev_urg = u;
            if (p == `AAM_URG_NONE) ev_code = `AAM_EV_DETECT;
            else if (u == `AAM_URG_NONE) ev_code = `AAM_EV_AUTORESET;
            else ev_code = `AAM_EV_LEVEL;
         end
      end
      // keys take the log slot before alarm changes; those retry next cycle
      sil_end = sil_r && (CANCEL_KEY || RESET_KEY || new_high || sil_cnt_r == 32'h00000001);
      if (SILENCE_KEY)
      begin
         ev_valid = 1'b1;
         ev_done = {N{1'b0}};
         ev_code = `AAM_EV_SILENCE;
         ev_urg = `AAM_URG_NONE;
         ev_id = {`AAM_IDW{1'b0}};
      end
      else if (sil_end)
      begin
         ev_valid = 1'b1;
         ev_done = {N{1'b0}};
         ev_code = `AAM_EV_SIL_END;
         ev_urg = `AAM_URG_NONE;
         ev_id = {`AAM_IDW{1'b0}};
      end
      // a reset entry pushed out by a silence entry is written the next cycle
      else if ((RESET_KEY && any_active) || rst_pend_r)
      begin
         ev_valid = 1'b1;
         ev_done = {N{1'b0}};
         ev_code = `AAM_EV_RESET;
         ev_urg = `AAM_URG_NONE;
         ev_id = {`AAM_IDW{1'b0}};
      end
      cls = any_high ? `AAM_URG_HIGH : any_med ? `AAM_URG_MED : any_low ? `AAM_URG_LOW : `AAM_URG_NONE;
      // one extra bit: pointer plus depth overflows the pointer width
      rd_w = {1'b0, wp_r} + {1'b0, DEPTH} - 8'h01 - {1'b0, LOG_IDX};
      rd_w = rd_w % {1'b0, DEPTH};
      rd = rd_w[`AAM_LOG_AW-1:0];
   end
   // prev urgency advances only for alarms whose change took the log slot, even when NEW_PATIENT_DONE drops the entry
   always @(posedge CLK)
   begin
      if (RESET)
      begin
         prev_urg_r <= {2*N{1'b0}};
         latch_high_r <= {N{1'b0}};
         ALM_REARM <= {N{1'b0}};
         wp_r <= 7'h00;
         LOG_COUNT <= 7'h00;
         LOG_UNREAD <= 1'b0;
         sil_r <= 1'b0;
         sil_cnt_r <= 32'h00000000;
         LOG_DATA <= {EW{1'b0}};
         rst_pend_r <= 1'b0;
      end
      else
      begin
         for (j = 0; j < N; j = j + 1)
         begin
            if (ev_done[j]) prev_urg_r[2*j +: 2] <= urg_of(ALM_URG, j);
            // limit change on a high alarm does not drop the latch
            if (urg_of(ALM_URG, j) == `AAM_URG_HIGH) latch_high_r[j] <= 1'b1;
            else if (RESET_KEY) latch_high_r[j] <= 1'b0;
         end
         // re-arm pulse; flush/calibration is not an alarm here and is untouched
         ALM_REARM <= {N{RESET_KEY}} & ~`AAM_RESET_EXEMPT;
         rst_pend_r <= ((RESET_KEY && any_active) || rst_pend_r) && (SILENCE_KEY || sil_end);
         if (NEW_PATIENT_DONE)
         begin
            wp_r <= 7'h00;
            LOG_COUNT <= 7'h00;
            LOG_UNREAD <= 1'b0;
         end
         else if (ev_valid)
         begin
            log_mem[wp_r] <= {TIME_NOW, ev_code, ev_urg, ev_id};
            wp_r <= (wp_r == DEPTH - 7'h01) ? 7'h00 : wp_r + 7'h01;
            if (LOG_COUNT != DEPTH) LOG_COUNT <= LOG_COUNT + 7'h01;
            LOG_UNREAD <= 1'b1;
         end
         else if (LOG_VIEWED)
            LOG_UNREAD <= 1'b0;
         LOG_DATA <= log_mem[rd];
         if (SILENCE_KEY)
         begin
            sil_r <= 1'b1;
            sil_cnt_r <= SILENCE_CYC;
         end
         else if (sil_end)
         begin
            sil_r <= 1'b0;
            sil_cnt_r <= 32'h00000000;
         end
         else if (sil_r)
            sil_cnt_r <= sil_cnt_r - 32'h00000001;
      end
   end
   // flash timebases and tone sequencer
   always @(posedge CLK)
   begin
      if (RESET)
      begin
         fl_cnt_r <= 32'h00000000;
         fast_r <= 1'b0;
         slow_r <= 1'b0;
         tone_cnt_r <= 32'h00000000;
         step_r <= 5'h00;
         low_done_r <= 1'b0;
         cls_prev_r <= 2'h0;
         LAMP_HIGH <= 1'b0;
         LAMP_MED <= 1'b0;
         LAMP_LOW <= 1'b0;
         LAMP_SILENCE <= 1'b0;
         TONE_ON <= 1'b0;
         TONE_CLASS <= 2'h0;
      end
      else
      begin
         if (cls == `AAM_URG_NONE)
         begin
            // park the flash phase lit so a fresh alarm lamp shows at once
            fl_cnt_r <= 32'h00000000;
            fast_r <= 1'b1;
            slow_r <= 1'b1;
         end
         else
         begin
            fl_cnt_r <= (fl_cnt_r == 2 * SLOW_CYC - 1) ? 32'h00000000 : fl_cnt_r + 32'h00000001;
            if (fl_cnt_r % FAST_CYC == FAST_CYC - 1) fast_r <= ~fast_r;
            if (fl_cnt_r % SLOW_CYC == SLOW_CYC - 1) slow_r <= ~slow_r;
         end
         cls_prev_r <= cls;
         // pattern restarts when the top class changes
         if (cls != cls_prev_r || tone_cnt_r == TONE_CYC - 1)
            tone_cnt_r <= 32'h00000000;
         else
            tone_cnt_r <= tone_cnt_r + 32'h00000001;
         if (cls != cls_prev_r)
         begin
            step_r <= 5'h00;
            low_done_r <= 1'b0;
         end
         else if (tone_cnt_r == TONE_CYC - 1)
         begin
            case (cls)
               // steps 0-9: tone/gap x5; 10-19 again; 20-23 pause
               `AAM_URG_HIGH: step_r <= (step_r == 5'd23) ? 5'h00 : step_r + 5'h01;
               `AAM_URG_MED: step_r <= (step_r == 5'd7) ? 5'h00 : step_r + 5'h01;
               `AAM_URG_LOW:
               begin
                  if (step_r == 5'd3) low_done_r <= 1'b1;
                  else step_r <= step_r + 5'h01;
               end
               default: step_r <= 5'h00;
            endcase
         end
         case (cls)
            `AAM_URG_HIGH: TONE_ON <= !sil_r && step_r < 5'd20 && !step_r[0];
            `AAM_URG_MED: TONE_ON <= !sil_r && step_r < 5'd6 && !step_r[0];
            `AAM_URG_LOW: TONE_ON <= !sil_r && !low_done_r && !step_r[0];
            default: TONE_ON <= 1'b0;
         endcase
         TONE_CLASS <= cls;
         LAMP_HIGH <= any_high ? fast_r : (|latch_high_r);
         LAMP_MED <= any_med & slow_r;
         LAMP_LOW <= any_low;
         LAMP_SILENCE <= sil_r;
      end
   end
endmodule // aam_alarm_manager
`default_nettype wire

/* File: aam_defines.vh */
`ifndef AAM_DEFINES_VH
`define AAM_DEFINES_VH
// alarm count and id width
`define AAM_NALM 16
`define AAM_IDW 4
// alarms kept out of reset re-arming: power, supply, sensor, self-test, procedure
`define AAM_RESET_EXEMPT 16'h07FF
// log geometry
`define AAM_LOG_DEPTH 80
`define AAM_LOG_AW 7
`define AAM_TSW 32
// event codes
`define AAM_EV_DETECT 3'h0
`define AAM_EV_LEVEL 3'h1
`define AAM_EV_AUTORESET 3'h2
`define AAM_EV_RESET 3'h3
`define AAM_EV_SILENCE 3'h4
`define AAM_EV_SIL_END 3'h5
// urgency codes
`define AAM_URG_NONE 2'h0
`define AAM_URG_LOW 2'h1
`define AAM_URG_MED 2'h2
`define AAM_URG_HIGH 2'h3
// timing: clock rate and silence length
`define AAM_CLK_HZ 20000000
`define AAM_SILENCE_S 120
`define AAM_SILENCE_CYC (`AAM_SILENCE_S * `AAM_CLK_HZ)
// flash half periods in ms, converted to cycles
`define AAM_FAST_MS 125
`define AAM_SLOW_MS 500
`define AAM_FAST_CYC (`AAM_FAST_MS * (`AAM_CLK_HZ / 1000))
`define AAM_SLOW_CYC (`AAM_SLOW_MS * (`AAM_CLK_HZ / 1000))
// tone step length
`define AAM_TONE_MS 150
`define AAM_TONE_CYC (`AAM_TONE_MS * (`AAM_CLK_HZ / 1000))
`endif

/* File: aam_alarm_manager_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module aam_alarm_manager_sva (
   // clock and reset
   input wire CLK,
   input wire RESET,
   // detector and key side
   input wire [31:0] ALM_URG,
   input wire [15:0] ALM_REARM,
   input wire SILENCE_KEY,
   input wire RESET_KEY,
   input wire CANCEL_KEY,
   input wire NEW_PATIENT_DONE,
   // indicators and log
   input wire LAMP_HIGH,
   input wire LAMP_SILENCE,
   input wire TONE_ON,
   input wire [6:0] LOG_COUNT,
   input wire LOG_UNREAD
);
   wire hi_now = |(ALM_URG & (ALM_URG >> 1) & 32'h5555_5555);
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   rearm_exempt_a: assert property (ALM_REARM[10:0] == 11'h000) else $error("exempt re-armed");
   rearm_cause_a: assert property (!RESET_KEY |=> ALM_REARM == 16'h0000) else $error("stray re-arm");
   sil_lamp_a: assert property (SILENCE_KEY |-> ##2 LAMP_SILENCE) else $error("silence lamp off");
   sil_mute_a: assert property (LAMP_SILENCE && $past(LAMP_SILENCE) |-> !TONE_ON) else $error("tone while muted");
   sil_log_a: assert property (SILENCE_KEY && !NEW_PATIENT_DONE && LOG_COUNT < 7'h50
      |=> LOG_COUNT == $past(LOG_COUNT) + 7'h01) else $error("press not logged");
   entry_unread_a: assert property (SILENCE_KEY |=> LOG_UNREAD) else $error("unread flag low");
   reset_unsil_a: assert property (RESET_KEY && !SILENCE_KEY |-> ##2 !LAMP_SILENCE) else $error("reset kept silence");
   cancel_unsil_a: assert property (CANCEL_KEY && !SILENCE_KEY |-> ##2 !LAMP_SILENCE) else $error("cancel ignored");
   high_steady_a: assert property (!hi_now && !$past(hi_now) && !$past(hi_now, 2) && !$past(RESET_KEY)
      && LAMP_HIGH && !RESET_KEY |=> LAMP_HIGH) else $error("red lamp not steady");
   reset_red_a: assert property (RESET_KEY && !hi_now ##1 !hi_now [*3] |-> !LAMP_HIGH) else $error("red lamp kept");
   log_max_a: assert property (LOG_COUNT <= 7'h50) else $error("log over 80");
   log_erase_a: assert property (NEW_PATIENT_DONE |=> LOG_COUNT <= 7'h01) else $error("log not erased");
endmodule // aam_alarm_manager_sva
bind aam_alarm_manager aam_alarm_manager_sva u_sva (.CLK(CLK), .RESET(RESET), .ALM_URG(ALM_URG),
   .ALM_REARM(ALM_REARM), .SILENCE_KEY(SILENCE_KEY), .RESET_KEY(RESET_KEY), .CANCEL_KEY(CANCEL_KEY),
   .NEW_PATIENT_DONE(NEW_PATIENT_DONE), .LAMP_HIGH(LAMP_HIGH), .LAMP_SILENCE(LAMP_SILENCE),
   .TONE_ON(TONE_ON), .LOG_COUNT(LOG_COUNT), .LOG_UNREAD(LOG_UNREAD));
`default_nettype wire

/* File: aam_detectors.sv */
`timescale 1ns/100ps
`default_nettype none
module aam_detectors (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // conditions set by the bench
   input wire logic [31:0] cond_urg,
   // manager side
   input wire logic [15:0] rearm,
   output logic [31:0] alm_urg
);
   logic [15:0] q1_r;
   logic [15:0] q2_r;
   always @(posedge clk)
   begin
      q1_r <= reset ? 16'h0000 : rearm;
      q2_r <= reset ? 16'h0000 : q1_r;
   end
   // restarted detector is blind two cycles, so a persisting condition shows as clear then new
   always @*
   begin
      for (int i = 0; i < 16; i++)
         alm_urg[2*i +: 2] = (q1_r[i] | q2_r[i]) ? 2'h0 : cond_urg[2*i +: 2];
   end
endmodule // aam_detectors
`default_nettype wire

/* File: aam_alarm_manager_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module aam_alarm_manager_tb;
   logic CLK = 0, RESET = 1, SILENCE_KEY = 0, RESET_KEY = 0, CANCEL_KEY = 0, NEW_PATIENT_DONE = 0, viewed = 0;
   logic [31:0] cond = 32'h0, TIME_NOW = 32'h0, ALM_URG;
   logic [15:0] ALM_REARM, sil_brk = 16'hFFFF, lim = 16'h0000;
   logic [6:0] LOG_IDX = 7'h00, LOG_COUNT;
   logic [40:0] LOG_DATA;
   logic LAMP_HIGH, LAMP_MED, LAMP_LOW, LAMP_SILENCE, TONE_ON, LOG_UNREAD;
   logic [1:0] TONE_CLASS;
   int errors = 0, num_checks = 0;
   always #25 CLK = ~CLK;
   always @(negedge CLK) TIME_NOW <= TIME_NOW + 32'h1;
   // short silence so the timeout is reachable
   aam_alarm_manager #(.SILENCE_CYC(32'h0000_00C8)) uut (.CLK(CLK), .RESET(RESET), .ALM_URG(ALM_URG),
      .ALM_LIMIT_CHG(lim), .ALM_SIL_BREAK(sil_brk), .ALM_REARM(ALM_REARM), .SILENCE_KEY(SILENCE_KEY),
      .RESET_KEY(RESET_KEY), .CANCEL_KEY(CANCEL_KEY), .NEW_PATIENT_DONE(NEW_PATIENT_DONE), .LOG_VIEWED(viewed),
      .TIME_NOW(TIME_NOW), .LAMP_HIGH(LAMP_HIGH), .LAMP_MED(LAMP_MED), .LAMP_LOW(LAMP_LOW),
      .LAMP_SILENCE(LAMP_SILENCE), .TONE_ON(TONE_ON), .TONE_CLASS(TONE_CLASS), .LOG_IDX(LOG_IDX),
      .LOG_DATA(LOG_DATA), .LOG_COUNT(LOG_COUNT), .LOG_UNREAD(LOG_UNREAD));
   aam_detectors det (.clk(CLK), .reset(RESET), .cond_urg(cond), .rearm(ALM_REARM), .alm_urg(ALM_URG));
   task automatic chk(input logic [40:0] got, input logic [40:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge CLK);
   endtask
   task automatic key(ref logic k);
      k = 1'b1;
      cyc(1);
      k = 1'b0;
   endtask
   // newest entry: event code, then urgency and id when full is set
   task automatic ent(input logic [2:0] ev, input logic [5:0] ui, input logic full);
      cyc(3);
      chk({LOG_DATA[8:6], full ? LOG_DATA[5:0] : ui}, {ev, ui});
   endtask
   task automatic wait_quiet(input int n);
      int i;
      for (i = 0; i < n && LAMP_SILENCE !== 1'b0; i++)
         cyc(1);
      if (i == n)
      begin
         errors++;
         finish_test();
      end
   endtask
   task automatic t_silence();
      key(SILENCE_KEY);
      cyc(2);
      chk(LOG_COUNT, 7'h01);
      ent(3'h4, 6'h00, 1'b0);
      cyc(150);
      chk(LAMP_SILENCE, 1'b1);
      key(SILENCE_KEY);
      cyc(150);
      chk(LAMP_SILENCE, 1'b1);
      wait_quiet(60);
      ent(3'h5, 6'h00, 1'b0);
      key(SILENCE_KEY);
      cyc(5);
      key(RESET_KEY);
      cyc(2);
      chk(LAMP_SILENCE, 1'b0);
      chk(LOG_COUNT, 7'h05);
      ent(3'h5, 6'h00, 1'b0);
      $display("t_silence done");
   endtask
   task automatic t_break();
      sil_brk = 16'hDFFF;
      key(SILENCE_KEY);
      cond[27:26] = 2'h3;
      cyc(4);
      chk(LAMP_SILENCE, 1'b1);
      chk(LAMP_HIGH, 1'b1);
      ent(3'h0, 6'h3D, 1'b1);
      cond[29:28] = 2'h3;
      wait_quiet(5);
      cyc(3);
      chk(TONE_ON, 1'b1);
      chk(TONE_CLASS, 2'h3);
      cond = 32'h0;
      lim = 16'h6000;
      cyc(4);
      chk(LAMP_HIGH, 1'b1);
      lim = 16'h0000;
      ent(3'h2, 6'h0E, 1'b1);
      key(SILENCE_KEY);
      cyc(2);
      key(CANCEL_KEY);
      cyc(2);
      chk(LAMP_SILENCE, 1'b0);
      key(RESET_KEY);
      cyc(4);
      chk(LAMP_HIGH, 1'b0);
      chk(LOG_COUNT, 7'h0D);
      $display("t_break done");
   endtask
   task automatic t_rearm();
      logic [15:0] r;
      cond[25:24] = 2'h2;
      cond[7:6] = 2'h1;
      cyc(4);
      chk({LAMP_MED, LAMP_LOW}, 2'h3);
      ent(3'h0, 6'h2C, 1'b1);
      key(RESET_KEY);
      r = ALM_REARM;
      cyc(1);
      chk((r | ALM_REARM) & 16'h17FF, 16'h1000);
      cyc(10);
      chk(LOG_COUNT, 7'h12);
      ent(3'h0, 6'h2C, 1'b1);
      cond = 32'h0;
      cyc(4);
      chk({LAMP_MED, LAMP_LOW}, 2'h0);
      ent(3'h2, 6'h0C, 1'b1);
      $display("t_rearm done");
   endtask
   task automatic t_log();
      logic [31:0] t;
      key(NEW_PATIENT_DONE);
      cyc(2);
      chk(LOG_COUNT, 7'h00);
      for (int i = 0; i < 85; i++)
      begin
         key(SILENCE_KEY);
         cyc(1);
      end
      cyc(4);
      chk(LOG_COUNT, 7'h50);
      chk(LOG_UNREAD, 1'b1);
      t = LOG_DATA[40:9];
      LOG_IDX = 7'h01;
      cyc(3);
      chk(t - LOG_DATA[40:9], 32'h2);
      key(viewed);
      chk(LOG_UNREAD, 1'b0);
      $display("t_log done");
   endtask
   initial
   begin
      cyc(12);
      RESET = 1'b0;
      cyc(1);
      t_silence();
      t_break();
      t_rearm();
      t_log();
      finish_test();
   end
endmodule // aam_alarm_manager_tb
`default_nettype wire
